/* File: plt_ctrl.sv */
`default_nettype none
`include "plt_regs.svh"
module plt_ctrl #(
  parameter int HIST_W = `CMP_DEPTH_LONG
) (
  input  wire logic                  clock,
  input  wire logic                  nrst,
  input  wire logic                  ce,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output var  logic                  s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output var  logic                  s_axi_wready,
  output var  logic [1:0]            s_axi_bresp,
  output var  logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output var  logic                  s_axi_arready,
  output var  logic [31:0]           s_axi_rdata,
  output var  logic [1:0]            s_axi_rresp,
  output var  logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  cmp0_result_in,
  input  wire logic                  cmp1_result_in,
  input  wire logic                  line_opamp_status_in,
  output var  logic                  tx_pin_route,
  output var  logic                  sense_route,
  output var  logic                  receive_route,
  output var  plt_pkg::dac_code_type dac0_code,
  output var  plt_pkg::dac_code_type dac1_code,
  output var  plt_pkg::dac_code_type dac2_code,
  output var  logic                  dac0_on,
  output var  logic                  dac1_on,
  output var  logic                  dac2_on,
  output var  logic                  cmp0_on,
  output var  logic                  cmp1_on,
  output var  plt_pkg::bias_sel_type cmp0_bias_current,
  output var  plt_pkg::bias_sel_type cmp1_bias_current,
  output var  logic [3:0]            cmp_hysteresis,
  output var  logic [6:0]            cmp0_offset_trim,
  output var  logic [6:0]            cmp1_offset_trim,
  output var  logic                  line_opamp_on,
  output var  logic                  line_opamp_wide_bw,
  output var  logic [7:0]            line_opamp_offset_trim,
  output var  logic                  cmp_out
);
  // write channel capture
  logic                  aw_held_ff;
  logic [7:0]            aw_addr_ff;
  logic                  w_held_ff;
  logic [7:0]            w_data_ff;
  logic                  w_lane0_ff;
  logic                  bvalid_ff;
  logic [1:0]            bresp_ff;
  logic                  wr_go;
  logic                  wr_hit;
  logic                  wr_en;
  // read channel
  logic                  rvalid_ff;
  logic [31:0]           rdata_ff;
  logic [1:0]            rresp_ff;
  plt_pkg::reg_byte_type rd_byte;
  logic                  rd_hit;
  // register storage
  plt_pkg::reg_byte_type line_switch_select_ff;
  plt_pkg::reg_byte_type dac_enable_ctrl_ff;
  plt_pkg::reg_byte_type dac0_code_ff;
  plt_pkg::reg_byte_type dac1_code_ff;
  plt_pkg::reg_byte_type dac2_code_ff;
  plt_pkg::reg_byte_type comparator0_ctrl_ff;
  plt_pkg::reg_byte_type comparator1_ctrl_ff;
  plt_pkg::reg_byte_type comparator0_offset_trim_ff;
  plt_pkg::reg_byte_type comparator1_offset_trim_ff;
  plt_pkg::reg_byte_type comparator_polarity_hysteresis_ff;
  plt_pkg::reg_byte_type line_opamp_ctrl_ff;
  plt_pkg::reg_byte_type line_opamp_offset_trim_ff;
  logic                  cmp_out_ff;
  logic [2:0]            sync_q;
  logic                  opamp_status;

  cmp_link c0_if ();
  cmp_link c1_if ();

  // ---- write path: address and data taken in either order
  assign s_axi_awready = ce & ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready  = ce & ~w_held_ff & ~bvalid_ff;
  assign wr_go         = ce & aw_held_ff & w_held_ff & ~bvalid_ff;
  assign wr_en         = wr_go & wr_hit & w_lane0_ff;

  always_comb begin
    case (aw_addr_ff)
      `OFS_LINE_SWITCH, `OFS_DAC_ENABLE, `OFS_DAC0_CODE, `OFS_DAC1_CODE,
      `OFS_DAC2_CODE, `OFS_CMP0_CTRL, `OFS_CMP1_CTRL, `OFS_CMP0_TRIM,
      `OFS_CMP1_TRIM, `OFS_CMP_POL_HYS, `OFS_OPAMP_CTRL,
      `OFS_OPAMP_TRIM: wr_hit = 1'h1;
      default:         wr_hit = 1'h0;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      aw_held_ff <= 1'h0;
      aw_addr_ff <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'h1;
      aw_addr_ff <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_ff <= 1'h0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      w_held_ff  <= 1'h0;
      w_data_ff  <= 8'h00;
      w_lane0_ff <= 1'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff  <= 1'h1;
      w_data_ff  <= s_axi_wdata[7:0];
      w_lane0_ff <= s_axi_wstrb[0];
    end else if (wr_go) begin
      w_held_ff <= 1'h0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bvalid_ff <= 1'h0;
      bresp_ff  <= `RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'h1;
      bresp_ff  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (ce && s_axi_bready) begin
      bvalid_ff <= 1'h0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // ---- register file; masks keep unimplemented bits at zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      line_switch_select_ff             <= `RST_LINE_SWITCH;
      dac_enable_ctrl_ff                <= `RST_DAC_ENABLE;
      dac0_code_ff                      <= `RST_DAC_CODE;
      dac1_code_ff                      <= `RST_DAC_CODE;
      dac2_code_ff                      <= `RST_DAC_CODE;
      comparator0_ctrl_ff               <= `RST_CMP_CTRL;
      comparator1_ctrl_ff               <= `RST_CMP_CTRL;
      comparator0_offset_trim_ff        <= `RST_CMP_TRIM;
      comparator1_offset_trim_ff        <= `RST_CMP_TRIM;
      comparator_polarity_hysteresis_ff <= `RST_CMP_POL_HYS;
      line_opamp_ctrl_ff                <= `RST_OPAMP_CTRL;
      line_opamp_offset_trim_ff         <= `RST_OPAMP_TRIM;
    end else if (wr_en) begin
      case (aw_addr_ff)
        `OFS_LINE_SWITCH: line_switch_select_ff <= w_data_ff & `WMASK_LINE_SWITCH;
        `OFS_DAC_ENABLE:  dac_enable_ctrl_ff <= w_data_ff & `WMASK_DAC_ENABLE;
        `OFS_DAC0_CODE:   dac0_code_ff <= w_data_ff & `WMASK_DAC_CODE;
        `OFS_DAC1_CODE:   dac1_code_ff <= w_data_ff & `WMASK_DAC_CODE;
        `OFS_DAC2_CODE:   dac2_code_ff <= w_data_ff & `WMASK_DAC_CODE;
        `OFS_CMP0_CTRL:   comparator0_ctrl_ff <= w_data_ff & `WMASK_CMP_CTRL;
        `OFS_CMP1_CTRL:   comparator1_ctrl_ff <= w_data_ff & `WMASK_CMP_CTRL;
        `OFS_CMP0_TRIM:   comparator0_offset_trim_ff <= w_data_ff & `WMASK_CMP_TRIM;
        `OFS_CMP1_TRIM:   comparator1_offset_trim_ff <= w_data_ff & `WMASK_CMP_TRIM;
        `OFS_CMP_POL_HYS: begin
          comparator_polarity_hysteresis_ff <= w_data_ff & `WMASK_CMP_POL_HYS;
        end
        `OFS_OPAMP_CTRL:  line_opamp_ctrl_ff <= w_data_ff & `WMASK_OPAMP_CTRL;
        `OFS_OPAMP_TRIM:  line_opamp_offset_trim_ff <= w_data_ff & `WMASK_OPAMP_TRIM;
        default: ;
      endcase
    end
  end

  // ---- read path
  always_comb begin
    rd_hit  = 1'h1;
    rd_byte = 8'h00;
    case (s_axi_araddr)
      `OFS_LINE_SWITCH: rd_byte = line_switch_select_ff;
      `OFS_DAC_ENABLE:  rd_byte = dac_enable_ctrl_ff;
      `OFS_DAC0_CODE:   rd_byte = dac0_code_ff;
      `OFS_DAC1_CODE:   rd_byte = dac1_code_ff;
      `OFS_DAC2_CODE:   rd_byte = dac2_code_ff;
      `OFS_CMP0_CTRL: begin
        rd_byte                = comparator0_ctrl_ff;
        rd_byte[`BIT_CMP_RAW]  = c0_if.raw;
        rd_byte[`BIT_CMP_FILT] = c0_if.filtered;
      end
      `OFS_CMP1_CTRL: begin
        rd_byte                = comparator1_ctrl_ff;
        rd_byte[`BIT_CMP_RAW]  = c1_if.raw;
        rd_byte[`BIT_CMP_FILT] = c1_if.filtered;
      end
      `OFS_CMP0_TRIM:   rd_byte = comparator0_offset_trim_ff;
      `OFS_CMP1_TRIM:   rd_byte = comparator1_offset_trim_ff;
      `OFS_CMP_POL_HYS: rd_byte = comparator_polarity_hysteresis_ff;
      `OFS_OPAMP_CTRL: begin
        rd_byte                   = line_opamp_ctrl_ff;
        rd_byte[`BIT_OPAMP_STATUS] = opamp_status;
      end
      `OFS_OPAMP_TRIM:  rd_byte = line_opamp_offset_trim_ff;
      default:          rd_hit  = 1'h0;
    endcase
  end

  assign s_axi_arready = ce & ~rvalid_ff;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rvalid_ff <= 1'h0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'h1;
      rdata_ff  <= {24'h00_0000, rd_byte};
      rresp_ff  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (ce && s_axi_rready) begin
      rvalid_ff <= 1'h0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  // ---- analogue controls
  assign tx_pin_route           = line_switch_select_ff[`BIT_TX_ROUTE];
  assign sense_route            = line_switch_select_ff[`BIT_SENSE_ROUTE];
  assign receive_route          = line_switch_select_ff[`BIT_RECV_ROUTE];
  assign dac0_on                = dac_enable_ctrl_ff[0];
  assign dac1_on                = dac_enable_ctrl_ff[1];
  assign dac2_on                = dac_enable_ctrl_ff[2];
  assign dac0_code              = dac0_code_ff[5:0];
  assign dac1_code              = dac1_code_ff[5:0];
  assign dac2_code              = dac2_code_ff[5:0];
  assign cmp0_on                = comparator0_ctrl_ff[`BIT_CMP_ON];
  assign cmp1_on                = comparator1_ctrl_ff[`BIT_CMP_ON];
  assign cmp0_bias_current      = comparator0_ctrl_ff[1:0];
  assign cmp1_bias_current      = comparator1_ctrl_ff[1:0];
  assign cmp_hysteresis         = comparator_polarity_hysteresis_ff[3:0];
  assign cmp0_offset_trim       = comparator0_offset_trim_ff[6:0];
  assign cmp1_offset_trim       = comparator1_offset_trim_ff[6:0];
  assign line_opamp_on          = line_opamp_ctrl_ff[`BIT_OPAMP_ON];
  assign line_opamp_wide_bw     = line_opamp_ctrl_ff[`BIT_OPAMP_BW];
  assign line_opamp_offset_trim = line_opamp_offset_trim_ff;

  // ---- comparator and op-amp status inputs into the clock domain
  cmp_sync2 #(
    .WIDTH (3)
  ) u_sync (
    .clock    (clock),
    .nrst     (nrst),
    .ce       (ce),
    .async_in ({line_opamp_status_in, cmp1_result_in, cmp0_result_in}),
    .sync_out (sync_q)
  );

  // op-amp status only visible in calibration mode
  assign opamp_status = sync_q[2] & line_opamp_offset_trim_ff[`BIT_OPAMP_CAL];

  assign c0_if.sample = sync_q[0];
  assign c0_if.on     = comparator0_ctrl_ff[`BIT_CMP_ON];
  assign c0_if.invert = comparator_polarity_hysteresis_ff[`BIT_CMP0_INVERT];
  assign c0_if.depth  = comparator0_ctrl_ff[`BIT_CMP_DEPTH_LO +: 2];
  assign c1_if.sample = sync_q[1];
  assign c1_if.on     = comparator1_ctrl_ff[`BIT_CMP_ON];
  assign c1_if.invert = comparator_polarity_hysteresis_ff[`BIT_CMP1_INVERT];
  assign c1_if.depth  = comparator1_ctrl_ff[`BIT_CMP_DEPTH_LO +: 2];

  cmp_channel #(
    .HIST_W (HIST_W)
  ) u_cmp0 (
    .clock (clock),
    .nrst  (nrst),
    .ce    (ce),
    .cif   (c0_if.chan)
  );

  cmp_channel #(
    .HIST_W (HIST_W)
  ) u_cmp1 (
    .clock (clock),
    .nrst  (nrst),
    .ce    (ce),
    .cif   (c1_if.chan)
  );

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cmp_out_ff <= 1'h0;
    end else if (ce) begin
      cmp_out_ff <= comparator_polarity_hysteresis_ff[`BIT_CMP_PICK] ?
                    c1_if.filtered : c0_if.filtered;
    end
  end

  assign cmp_out = cmp_out_ff;

  // ---- checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_wr(logic [7:0] addr);
    wr_en && aw_addr_ff == addr;
  endsequence

  sequence s_rd(logic [7:0] addr);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == addr;
  endsequence

  property p_tx_route;
    s_wr(`OFS_LINE_SWITCH) |=> tx_pin_route == $past(w_data_ff[`BIT_TX_ROUTE]);
  endproperty
  a_tx_route: assert property (p_tx_route)
    else $error("tx route did not follow write");

  property p_sense_route;
    s_wr(`OFS_LINE_SWITCH) |=> sense_route == $past(w_data_ff[`BIT_SENSE_ROUTE]);
  endproperty
  a_sense_route: assert property (p_sense_route)
    else $error("sense route did not follow write");

  property p_recv_route;
    s_wr(`OFS_LINE_SWITCH) |=> receive_route == $past(w_data_ff[`BIT_RECV_ROUTE]);
  endproperty
  a_recv_route: assert property (p_recv_route)
    else $error("receive route did not follow write");

  property p_unused_zero;
    s_rd(`OFS_LINE_SWITCH) |=> s_axi_rvalid && s_axi_rdata[31:3] == 29'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unimplemented switch bits read nonzero");

  property p_dac_enable;
    s_wr(`OFS_DAC_ENABLE) |=> {dac2_on, dac1_on, dac0_on} == $past(w_data_ff[2:0]);
  endproperty
  a_dac_enable: assert property (p_dac_enable)
    else $error("dac enables did not follow write");

  property p_dac_code;
    s_wr(`OFS_DAC1_CODE) |=> dac1_code == $past(w_data_ff[5:0]);
  endproperty
  a_dac_code: assert property (p_dac_code)
    else $error("dac code did not follow write");

  property p_raw_path;
    ce ##1 ce ##1 (ce && c0_if.on) |=>
      c0_if.raw == ($past(cmp0_result_in, 3) ^ $past(c0_if.invert));
  endproperty
  a_raw_path: assert property (p_raw_path)
    else $error("raw bit not input three cycles back");

  property p_status_read;
    s_rd(`OFS_CMP0_CTRL) |=> s_axi_rdata[`BIT_CMP_RAW] == $past(c0_if.raw)
      && s_axi_rdata[`BIT_CMP_FILT] == $past(c0_if.filtered) && !s_axi_rdata[4];
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("comparator status readback wrong");

  property p_invert_bit;
    s_wr(`OFS_CMP_POL_HYS) |=> c0_if.invert == $past(w_data_ff[`BIT_CMP0_INVERT]);
  endproperty
  a_invert_bit: assert property (p_invert_bit)
    else $error("comparator 0 polarity not at bit 4");

  property p_pick;
    ce |=> cmp_out == ($past(comparator_polarity_hysteresis_ff[`BIT_CMP_PICK]) ?
                       $past(c1_if.filtered) : $past(c0_if.filtered));
  endproperty
  a_pick: assert property (p_pick)
    else $error("comparator output pick wrong");
endmodule // plt_ctrl
`default_nettype wire

/* File: plt_regs.svh */
`ifndef PLT_REGS_SVH
`define PLT_REGS_SVH

// register byte offsets
`define OFS_LINE_SWITCH   8'h00
`define OFS_DAC_ENABLE    8'h04
`define OFS_DAC0_CODE     8'h08
`define OFS_DAC1_CODE     8'h0C
`define OFS_DAC2_CODE     8'h10
`define OFS_CMP0_CTRL     8'h14
`define OFS_CMP1_CTRL     8'h18
`define OFS_CMP0_TRIM     8'h1C
`define OFS_CMP1_TRIM     8'h20
`define OFS_CMP_POL_HYS   8'h24
`define OFS_OPAMP_CTRL    8'h28
`define OFS_OPAMP_TRIM    8'h2C

// reset values
`define RST_LINE_SWITCH   8'h01
`define RST_DAC_ENABLE    8'h00
`define RST_DAC_CODE      8'h00
`define RST_CMP_CTRL      8'h00
`define RST_CMP_TRIM      8'h10
`define RST_CMP_POL_HYS   8'h00
`define RST_OPAMP_CTRL    8'h00
`define RST_OPAMP_TRIM    8'h20

// writable bit masks, everything else reads zero except the comparator raw/filtered and op-amp status bits
`define WMASK_LINE_SWITCH 8'h07
`define WMASK_DAC_ENABLE  8'h07
`define WMASK_DAC_CODE    8'h3F
`define WMASK_CMP_CTRL    8'h4F
`define WMASK_CMP_TRIM    8'h7F
`define WMASK_CMP_POL_HYS 8'h7F
`define WMASK_OPAMP_CTRL  8'h41
`define WMASK_OPAMP_TRIM  8'hFF

// field positions
`define BIT_TX_ROUTE      0
`define BIT_SENSE_ROUTE   1
`define BIT_RECV_ROUTE    2
`define BIT_CMP_RAW       7
`define BIT_CMP_ON        6
`define BIT_CMP_FILT      5
`define BIT_CMP_DEPTH_LO  2
`define BIT_CMP0_INVERT   4
`define BIT_CMP1_INVERT   5
`define BIT_CMP_PICK      6
`define BIT_OPAMP_ON      6
`define BIT_OPAMP_STATUS  5
`define BIT_OPAMP_BW      0
`define BIT_OPAMP_CAL     7

// debounce history lengths in system clock samples
`define CMP_DEPTH_SHORT   31
`define CMP_DEPTH_MID     63
`define CMP_DEPTH_LONG    126

// bus responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

/* File: plt_pkg.sv */
`default_nettype none
package plt_pkg;
  typedef logic [7:0] reg_byte_type;
  typedef logic [5:0] dac_code_type;
  typedef logic [1:0] depth_sel_type;
  typedef logic [1:0] bias_sel_type;
endpackage
`default_nettype wire

/* File: cmp_link.sv */
`default_nettype none
interface cmp_link;
  logic                  sample;
  logic                  on;
  logic                  invert;
  plt_pkg::depth_sel_type depth;
  logic                  raw;
  logic                  filtered;
  modport ctrl (output sample, output on, output invert, output depth,
                input raw, input filtered);
  modport chan (input sample, input on, input invert, input depth,
                output raw, output filtered);
endinterface
`default_nettype wire

/* File: cmp_sync2.sv */
`default_nettype none
module cmp_sync2 #(
  parameter int WIDTH = 3
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  if (WIDTH < 1) begin : g_bad_width
    $error("cmp_sync2: WIDTH must be at least 1");
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else if (ce) begin
      stage1_ff <= async_in;
      stage2_ff <= stage1_ff;
    end
  end

  assign sync_out = stage2_ff;
endmodule // cmp_sync2
`default_nettype wire

/* File: cmp_channel.sv */
`default_nettype none
`include "plt_regs.svh"
module cmp_channel #(
  parameter int HIST_W = `CMP_DEPTH_LONG
) (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic ce,
  cmp_link.chan     cif
);
  logic              raw_ff;
  logic              filt_ff;
  logic [HIST_W-1:0] hist_ff;
  logic              lvl;
  logic              match;
  int                depth_n;
  logic [7:0]        run_ff;

  if (HIST_W < `CMP_DEPTH_LONG) begin : g_bad_hist
    $error("cmp_channel: HIST_W too small for the longest filter");
  end

  // asserted level follows polarity
  assign lvl = ~cif.invert;

  // disabled comparator reads as 0 before polarity
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      raw_ff <= 1'h0;
    end else if (ce) begin
      raw_ff <= (cif.on & cif.sample) ^ cif.invert;
    end
  end

  always_comb begin
    case (cif.depth)
      2'h0:    depth_n = 0;
      2'h1:    depth_n = `CMP_DEPTH_SHORT;
      2'h2:    depth_n = `CMP_DEPTH_MID;
      2'h3:    depth_n = `CMP_DEPTH_LONG;
      default: depth_n = 0;
    endcase
  end

  // current sample plus the selected history must all be at level
  always_comb begin
    match = (raw_ff == lvl);
    for (int i = 0; i < HIST_W; i++) begin
      if (i < depth_n && hist_ff[i] != lvl) begin
        match = 1'h0;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hist_ff <= '0;
      filt_ff <= 1'h0;
    end else if (ce) begin
      hist_ff <= {hist_ff[HIST_W-2:0], raw_ff};
      filt_ff <= match ? lvl : ~lvl;
    end
  end

  assign cif.raw      = raw_ff;
  assign cif.filtered = filt_ff;

  // streak of ones, read only by the checks below
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      run_ff <= 8'h00;
    end else if (ce) begin
      run_ff <= !raw_ff ? 8'h00 : (run_ff == 8'hFF) ? run_ff : run_ff + 8'h01;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_filter_rise;
    ce && !cif.invert && cif.depth == 2'h1 && !filt_ff ##1 filt_ff;
  endsequence

  property p_off_forces_zero;
    ce && !cif.on |=> raw_ff == $past(cif.invert);
  endproperty
  a_off_forces_zero: assert property (p_off_forces_zero)
    else $error("disabled comparator raw bit wrong");

  property p_mismatch_releases;
    ce && raw_ff != lvl |=> filt_ff != $past(lvl);
  endproperty
  a_mismatch_releases: assert property (p_mismatch_releases)
    else $error("filtered bit asserted on mismatching sample");

  property p_short_filter_len;
    s_filter_rise |-> run_ff >= 8'd32;
  endproperty
  a_short_filter_len: assert property (p_short_filter_len)
    else $error("filtered bit rose before 32 matching samples");
endmodule // cmp_channel
`default_nettype wire

/* File: line_network.sv */
`default_nettype none
module line_network (
  input  wire logic above,
  output var  logic cmp0_res,
  output var  logic cmp1_res,
  output var  logic opamp_st
);
  timeunit 1ns;
  timeprecision 1ns;
  // comparator 1 sees the opposite line swing
  assign cmp0_res = above;
  assign cmp1_res = ~above;
  assign opamp_st = above;
endmodule // line_network
`default_nettype wire

/* File: power_line_transceiver_ctrl_tb.sv */
`default_nettype none
`include "plt_regs.svh"
module power_line_transceiver_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'h0, nrst = 1'h0, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0;
  logic        rr = 1'h0, above = 1'h0, bv, rv, awr, wrd, arr, c0, c1, ops;
  logic        tx, sn, rx, d0on, cout;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0000_0000, rd;
  logic [1:0]  bresp, rresp;
  logic [5:0]  d0;
  logic        en = 1'h1;
  int          failures, samples_checked, cyc;
  plt_ctrl dut (.clock(clock), .nrst(nrst), .ce(en), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .cmp0_result_in(c0),
    .cmp1_result_in(c1), .line_opamp_status_in(ops), .tx_pin_route(tx), .sense_route(sn),
    .receive_route(rx), .dac0_code(d0), .dac1_code(), .dac2_code(), .dac0_on(d0on),
    .dac1_on(), .dac2_on(), .cmp0_on(), .cmp1_on(), .cmp0_bias_current(),
    .cmp1_bias_current(), .cmp_hysteresis(), .cmp0_offset_trim(), .cmp1_offset_trim(),
    .line_opamp_on(), .line_opamp_wide_bw(), .line_opamp_offset_trim(), .cmp_out(cout));
  line_network far (.above(above), .cmp0_res(c0), .cmp1_res(c1), .opamp_st(ops));
  initial begin
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic       aw_go;
    logic       w_go;
    logic       b_go;
    logic [1:0] resp;
    awa <= a;
    wd <= {24'h00_0000, d};
    awv <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    aw_go = 1'h0;
    w_go = 1'h0;
    // readies sampled mid-cycle, they stand unchanged up to the next edge
    while (!(aw_go && w_go)) begin
      @(negedge clock);
      if (awv && awr === 1'h1) aw_go = 1'h1;
      if (wv && wrd === 1'h1) w_go = 1'h1;
      @(posedge clock);
      if (aw_go) awv <= 1'h0;
      if (w_go) wv <= 1'h0;
    end
    b_go = 1'h0;
    while (!b_go) begin
      @(negedge clock);
      b_go = (bv === 1'h1);
      resp = bresp;
      @(posedge clock);
    end
    br <= 1'h0;
    @(posedge clock);
    chk(resp, `RESP_OKAY);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                     input logic [1:0] er = `RESP_OKAY);
    logic        ar_go;
    logic        r_go;
    logic [31:0] got;
    logic [1:0]  resp;
    ara <= a;
    arv <= 1'h1;
    rr <= 1'h1;
    ar_go = 1'h0;
    while (!ar_go) begin
      @(negedge clock);
      ar_go = (arr === 1'h1);
      @(posedge clock);
    end
    arv <= 1'h0;
    r_go = 1'h0;
    while (!r_go) begin
      @(negedge clock);
      r_go = (rv === 1'h1);
      got = rd;
      resp = rresp;
      @(posedge clock);
    end
    rr <= 1'h0;
    @(posedge clock);
    chk(got & {24'h00_0000, m}, {24'h00_0000, e});
    chk(resp, er);
  endtask
  task automatic t_reset();
    rdc(`OFS_LINE_SWITCH, 8'hFF, 8'h01);
    rdc(`OFS_DAC_ENABLE, 8'hFF, 8'h00);
    rdc(`OFS_DAC0_CODE, 8'hFF, 8'h00);
    rdc(`OFS_CMP0_CTRL, 8'hFF, 8'h00);
    rdc(8'h30, 8'hFF, 8'h00, `RESP_SLVERR);
  endtask
  task automatic t_regs();
    wr(`OFS_LINE_SWITCH, 8'hFE);
    rdc(`OFS_LINE_SWITCH, 8'hFF, 8'h06);
    chk({rx, sn, tx}, 3'h6);
    wr(`OFS_DAC0_CODE, 8'hFF);
    rdc(`OFS_DAC0_CODE, 8'hFF, 8'h3F);
    chk(d0, 6'h3F);
    wr(`OFS_DAC1_CODE, 8'hEA);
    rdc(`OFS_DAC1_CODE, 8'hFF, 8'h2A);
    wr(`OFS_DAC_ENABLE, 8'hF9);
    chk(d0on, 1'h1);
  endtask
  task automatic t_cmp();
    above <= 1'h1;
    wr(`OFS_CMP0_CTRL, 8'hC0);
    repeat (8) @(posedge clock);
    rdc(`OFS_CMP0_CTRL, 8'hA0, 8'hA0);
    chk(cout, 1'h1);
    wr(`OFS_CMP_POL_HYS, 8'h10);
    repeat (8) @(posedge clock);
    rdc(`OFS_CMP0_CTRL, 8'hA0, 8'h00);
    wr(`OFS_CMP0_CTRL, 8'h00);
    repeat (8) @(posedge clock);
    rdc(`OFS_CMP0_CTRL, 8'h80, 8'h80);
    // comparator 0 filtered now reads 1, comparator 1 reads 0
    wr(`OFS_CMP_POL_HYS, 8'h50);
    repeat (8) @(posedge clock);
    chk(cout, 1'h0);
    wr(`OFS_CMP_POL_HYS, 8'h00);
  endtask
  task automatic t_deb();
    for (int d = 1; d < 4; d++) begin
      above <= 1'h0;
      wr(`OFS_CMP0_CTRL, 8'h40 | 8'(d << 2));
      repeat (140) @(posedge clock);
      above <= 1'h1;
      repeat ((32 << (d - 1)) - 8) @(posedge clock);
      chk(cout, 1'h0);
      repeat (16) @(posedge clock);
      chk(cout, 1'h1);
    end
  endtask
  task automatic t_hold();
    en <= 1'h0;
    above <= 1'h0;
    repeat (140) @(posedge clock);
    chk({awr, arr, cout}, 3'h1);
    en <= 1'h1;
    repeat (140) @(posedge clock);
    chk(cout, 1'h0);
  endtask
  initial begin
    repeat (16) @(posedge clock);
    nrst <= 1'h1;
    @(posedge clock);
    t_reset();
    t_regs();
    t_cmp();
    t_deb();
    t_hold();
    results();
  end
endmodule // power_line_transceiver_ctrl_tb
`default_nettype wire
